// ---- rtl/mcr_clock_ctrl.sv ----
// Contract
// - CPU clock from oscillator via prescaler
// - Normal /2, slow /4 /8 /16 /32
// - CAN clock always oscillator divided by two
// - Clock-out enable drives oscillator over two
// - Clock-out stops during timed halt
// - Four selectable RTC periods
// - New time base at period end
// - Halt with irq enabled enters timed halt
// - Flag set on period, cleared by read
// - Bits 7 to 4 read zero
// - Reset value reads 01h
// - Interrupt when flag, enable, unmasked
// - Wait mode unchanged, interrupt wakes
// - Timed halt: counter runs, registers frozen
// - Full halt freezes RTC counter and registers, other wakeup
// - RTC interrupt cannot leave full halt
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module mcr_clock_ctrl
	import mcr_pkg::*;
#(
	parameter int PERIOD_W = 19,
	parameter logic [PERIOD_W-1:0] TB0_CYCLES = MCR_TB0_CYC,
	parameter logic [PERIOD_W-1:0] TB1_CYCLES = MCR_TB1_CYC,
	parameter logic [PERIOD_W-1:0] TB2_CYCLES = MCR_TB2_CYC,
	parameter logic [PERIOD_W-1:0] TB3_CYCLES = MCR_TB3_CYC
) (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// CPU state
	input wire logic halt_exec_in,
	input wire logic wait_mode_in,
	input wire logic cpu_irq_mask_in,
	input wire logic other_wake_in,
	// Clocks out
	output logic cpu_clk_en_out,
	output logic can_clk_out,
	output logic clk_out_out,
	output logic clk_out_oe_out,
	// Interrupt and status
	output logic rtc_irq_out,
	output logic wake_out,
	output logic irq_out,
	output logic timed_halt_out,
	output logic full_halt_out
);
	mcr_mode_t mode_q, mode_d;
	logic [1:0] tb_q, tb_act_q;
	logic ien_q, flag_q;
	logic [7:0] misc_q;
	logic [PERIOD_W-1:0] rtc_cnt_q;
	logic [3:0] cpu_cnt_q;
	logic cpu_half_q;
	logic can_q, clko_q, clkoe_q;
	logic [1:0] ist_q, imask_q;
	logic [7:0] rdata_q;
	logic rtc_irq_q, wake_q, irq_q;
	logic th_q, fh_q;

	wire sel_ccs = addr_in == MCR_CCS_ADDR;
	wire sel_misc = addr_in == MCR_MISC1_ADDR;
	wire sel_ist = addr_in == MCR_IRQ_STAT_ADDR;
	wire sel_imask = addr_in == MCR_IRQ_MASK_ADDR;
	wire running = mode_q == MCR_RUN;
	// Registers frozen outside run
	wire reg_ok = clk_en_in && running;
	wire counter_ok = clk_en_in && mode_q != MCR_FULL_HALT;
	// Period select
	logic [PERIOD_W-1:0] period_last;
	always_comb begin
		case (tb_act_q)
			2'h0: period_last = TB0_CYCLES - 1'b1;
			2'h1: period_last = TB1_CYCLES - 1'b1;
			2'h2: period_last = TB2_CYCLES - 1'b1;
			default: period_last = TB3_CYCLES - 1'b1;
		endcase
	end
	wire period_end = counter_ok && rtc_cnt_q == period_last;
	// Prescaler half period
	logic [3:0] half_last;
	always_comb begin
		if (!misc_q[MCR_SMS_BIT]) begin
			half_last = MCR_HALF_DIV2;
		end else begin
			case (misc_q[MCR_CP_HI:MCR_CP_LO])
				2'h0: half_last = MCR_HALF_DIV4;
				2'h1: half_last = MCR_HALF_DIV16;
				2'h2: half_last = MCR_HALF_DIV8;
				default: half_last = MCR_HALF_DIV32;
			endcase
		end
	end
	wire cpu_wrap = cpu_cnt_q >= half_last;
	wire ccs_rd = reg_ok && rd_in && sel_ccs;
	wire irq_cond = flag_q && ien_q && !cpu_irq_mask_in;
	wire [7:0] ccs_val = {4'h0, tb_q, ien_q, flag_q};
	wire [7:0] rd_mux = sel_ccs ? ccs_val :
		sel_misc ? misc_q :
		sel_ist ? {6'h00, ist_q} :
		sel_imask ? {6'h00, imask_q} : 8'h00;
	// Bit 1 enabled timeout, bit 0 any timeout
	wire [1:0] ev = {period_end && ien_q, period_end};
	wire clko_run = misc_q[MCR_MCO_BIT] && mode_d == MCR_RUN;

	// Mode sequencing
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MCR_RUN: begin
				if (halt_exec_in) begin
					mode_d = ien_q ? MCR_TIMED_HALT : MCR_FULL_HALT;
				end
			end
			MCR_TIMED_HALT: begin
				if ((period_end && ien_q) || other_wake_in) begin
					mode_d = MCR_RUN;
				end
			end
			MCR_FULL_HALT: begin
				if (other_wake_in) begin
					mode_d = MCR_RUN;
				end
			end
			default: mode_d = MCR_RUN;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mode_q <= MCR_RUN;
		end else if (clk_en_in) begin
			mode_q <= mode_d;
		end
	end

	// RTC divider
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rtc_cnt_q <= '0;
			tb_act_q <= MCR_TB_RST;
		end else if (period_end) begin
			rtc_cnt_q <= '0;
			tb_act_q <= tb_q;
		end else if (counter_ok) begin
			rtc_cnt_q <= rtc_cnt_q + 1'b1;
		end
	end

	// Control/status and misc registers
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tb_q <= MCR_TB_RST;
			ien_q <= MCR_IEN_RST;
			misc_q <= MCR_MISC1_RST;
		end else if (reg_ok && wr_in) begin
			if (sel_ccs) begin
				tb_q <= wdata_in[MCR_TB_HI:MCR_TB_LO];
				ien_q <= wdata_in[MCR_IEN_BIT];
			end
			if (sel_misc) begin
				misc_q <= wdata_in;
			end
		end
	end

	// Timeout flag, set wins over read clear
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			flag_q <= MCR_FLAG_RST;
		end else if (period_end) begin
			flag_q <= 1'b1;
		end else if (ccs_rd) begin
			flag_q <= 1'b0;
		end
	end

	// Sticky event bits and mask
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ist_q <= 2'h0;
			imask_q <= 2'h0;
		end else if (clk_en_in) begin
			if (reg_ok && wr_in && sel_imask) begin
				imask_q <= wdata_in[1:0];
			end
			if (reg_ok && wr_in && sel_ist) begin
				ist_q <= (ist_q & ~wdata_in[1:0]) | ev;
			end else begin
				ist_q <= ist_q | ev;
			end
		end
	end

	// Read data
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_q <= 8'h00;
		end else if (clk_en_in) begin
			rdata_q <= (reg_ok && rd_in) ? rd_mux : 8'h00;
		end
	end

	// CPU prescaler
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cpu_cnt_q <= 4'h0;
			cpu_half_q <= 1'b0;
		end else if (clk_en_in) begin
			if (cpu_wrap) begin
				cpu_cnt_q <= 4'h0;
				cpu_half_q <= ~cpu_half_q;
			end else begin
				cpu_cnt_q <= cpu_cnt_q + 1'b1;
			end
		end
	end

	// Fixed-rate CAN clock
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			can_q <= 1'b0;
		end else if (clk_en_in) begin
			can_q <= ~can_q;
		end
	end

	// Clock-out pin
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			clko_q <= 1'b0;
			clkoe_q <= 1'b0;
		end else if (clk_en_in) begin
			clkoe_q <= misc_q[MCR_MCO_BIT];
			if (clko_run) begin
				clko_q <= ~clko_q;
			end else begin
				clko_q <= 1'b0;
			end
		end
	end

	// Halt mode flags for the pins
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			th_q <= 1'b0;
			fh_q <= 1'b0;
		end else if (clk_en_in) begin
			th_q <= mode_d == MCR_TIMED_HALT;
			fh_q <= mode_d == MCR_FULL_HALT;
		end
	end

	// Interrupt and wake outputs
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rtc_irq_q <= 1'b0;
			wake_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (clk_en_in) begin
			rtc_irq_q <= irq_cond;
			// wake from wait or timed halt
			wake_q <= irq_cond &&
				(wait_mode_in || mode_q == MCR_TIMED_HALT);
			irq_q <= |(ist_q & imask_q);
		end
	end

	// wait mode leaves all logic running
	assign rdata_out = rdata_q;
	assign cpu_clk_en_out = cpu_half_q;
	assign can_clk_out = can_q;
	assign clk_out_out = clko_q;
	assign clk_out_oe_out = clkoe_q;
	assign rtc_irq_out = rtc_irq_q;
	assign wake_out = wake_q;
	assign irq_out = irq_q;
	assign timed_halt_out = th_q;
	assign full_halt_out = fh_q;
endmodule // mcr_clock_ctrl

// ---- rtl/mcr_pkg.sv ----
package mcr_pkg;
	// Register offsets
	localparam logic [7:0] MCR_CCS_ADDR = 8'h29;
	localparam logic [7:0] MCR_MISC1_ADDR = 8'h20;
	localparam logic [7:0] MCR_IRQ_STAT_ADDR = 8'h30;
	localparam logic [7:0] MCR_IRQ_MASK_ADDR = 8'h31;
	// Field positions in clock_ctl_status
	localparam int MCR_FLAG_BIT = 0;
	localparam int MCR_IEN_BIT = 1;
	localparam int MCR_TB_LO = 2;
	localparam int MCR_TB_HI = 3;
	// Field positions in misc_control_one
	localparam int MCR_SMS_BIT = 0;
	localparam int MCR_CP_LO = 1;
	localparam int MCR_CP_HI = 2;
	localparam int MCR_MCO_BIT = 5;
	// Reset values
	localparam logic [1:0] MCR_TB_RST = 2'h0;
	localparam logic MCR_IEN_RST = 1'b0;
	localparam logic MCR_FLAG_RST = 1'b1;
	localparam logic [7:0] MCR_MISC1_RST = 8'h00;
	// Time base periods in oscillator cycles
	localparam logic [18:0] MCR_TB0_CYC = 19'd32000;
	localparam logic [18:0] MCR_TB1_CYC = 19'd64000;
	localparam logic [18:0] MCR_TB2_CYC = 19'd160000;
	localparam logic [18:0] MCR_TB3_CYC = 19'd400000;
	// Divider: division ratios as half-period counts minus one
	localparam logic [3:0] MCR_HALF_DIV2 = 4'h0;
	localparam logic [3:0] MCR_HALF_DIV4 = 4'h1;
	localparam logic [3:0] MCR_HALF_DIV8 = 4'h3;
	localparam logic [3:0] MCR_HALF_DIV16 = 4'h7;
	localparam logic [3:0] MCR_HALF_DIV32 = 4'hf;
	typedef enum logic [1:0] {
		MCR_RUN,
		MCR_TIMED_HALT,
		MCR_FULL_HALT
	} mcr_mode_t;
endpackage

// ---- tb/mcr_clock_ctrl_chk.sv ----
`timescale 1ns/10ps
module mcr_clock_ctrl_chk (
	// Clock, reset
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Inputs watched
	input wire logic [7:0] addr_in,
	input wire logic rd_in,
	input wire logic halt_exec_in,
	input wire logic cpu_irq_mask_in,
	input wire logic other_wake_in,
	// Outputs watched
	input wire logic [7:0] rdata_out,
	input wire logic can_clk_out,
	input wire logic clk_out_out,
	input wire logic rtc_irq_out,
	input wire logic timed_halt_out,
	input wire logic full_halt_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence s_run;
		!timed_halt_out && !full_halt_out;
	endsequence
	sequence s_halt_req;
		halt_exec_in && clk_en_in ##0 s_run;
	endsequence
	property p_can;
		!$past(rst_in) && $past(clk_en_in) |-> $changed(can_clk_out);
	endproperty
	property p_rsv;
		$past(rd_in && addr_in == 8'h29) |-> rdata_out[7:4] == 4'h0;
	endproperty
	property p_irq;
		rtc_irq_out |-> !$past(cpu_irq_mask_in);
	endproperty
	property p_cko;
		clk_out_out && clk_en_in |=> !clk_out_out;
	endproperty
	property p_cko_th;
		timed_halt_out [*2] |-> !clk_out_out;
	endproperty
	property p_cko_fh;
		full_halt_out [*2] |-> !clk_out_out;
	endproperty
	property p_halt;
		s_halt_req |=> timed_halt_out || full_halt_out;
	endproperty
	property p_full;
		full_halt_out && !other_wake_in |=> full_halt_out;
	endproperty
	a_can: assert property (p_can) else $error("can clock stuck");
	a_rsv: assert property (p_rsv) else $error("upper bits set");
	a_irq: assert property (p_irq) else $error("irq while masked");
	a_cko: assert property (p_cko) else $error("clock out stuck");
	a_cko_th: assert property (p_cko_th) else $error("clock out runs");
	a_cko_fh: assert property (p_cko_fh) else $error("clock out runs");
	a_halt: assert property (p_halt) else $error("halt not taken");
	a_full: assert property (p_full) else $error("full halt left");
endmodule // mcr_clock_ctrl_chk
bind mcr_clock_ctrl mcr_clock_ctrl_chk u_chk (.clock_in(clock_in),
	.rst_in(rst_in), .clk_en_in(clk_en_in), .addr_in(addr_in), .rd_in(rd_in),
	.halt_exec_in(halt_exec_in), .cpu_irq_mask_in(cpu_irq_mask_in),
	.other_wake_in(other_wake_in), .rdata_out(rdata_out),
	.can_clk_out(can_clk_out), .clk_out_out(clk_out_out),
	.rtc_irq_out(rtc_irq_out), .timed_halt_out(timed_halt_out),
	.full_halt_out(full_halt_out));

// ---- tb/tb_mcr_clock_ctrl.sv ----
`timescale 1ns/10ps
module tb_mcr_clock_ctrl;
	logic clock_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic halt_exec_in = 1'b0, wait_mode_in = 1'b0;
	logic cpu_irq_mask_in = 1'b0, other_wake_in = 1'b0, clk_en_in = 1'b1;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
	logic cpu_clk_en_out, can_clk_out, clk_out_out, clk_out_oe_out;
	logic rtc_irq_out, wake_out, irq_out, timed_halt_out, full_halt_out;
	int failures = 0, checks_done = 0, cyc = 0, c0;
	always #4 clock_in = ~clock_in;
	always @(posedge clock_in) cyc <= cyc + 1;
	mcr_clock_ctrl #(.TB0_CYCLES(19'd20), .TB1_CYCLES(19'd40),
		.TB2_CYCLES(19'd100), .TB3_CYCLES(19'd250)) DUT (
		.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .halt_exec_in(halt_exec_in),
		.wait_mode_in(wait_mode_in), .cpu_irq_mask_in(cpu_irq_mask_in),
		.other_wake_in(other_wake_in), .cpu_clk_en_out(cpu_clk_en_out),
		.can_clk_out(can_clk_out), .clk_out_out(clk_out_out),
		.clk_out_oe_out(clk_out_oe_out), .rtc_irq_out(rtc_irq_out),
		.wake_out(wake_out), .irq_out(irq_out),
		.timed_halt_out(timed_halt_out), .full_halt_out(full_halt_out));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask
	task automatic pls(input logic h);
		@(posedge clock_in);
		halt_exec_in <= h;
		other_wake_in <= !h;
		@(posedge clock_in);
		halt_exec_in <= 1'b0;
		other_wake_in <= 1'b0;
		#1;
	endtask
	// Cycles between two rises of the CPU clock
	task automatic per(input logic [7:0] m, input int e);
		int n;
		int k;
		logic p;
		wr(8'h20, m);
		repeat (70) @(posedge clock_in);
		n = 0;
		k = 0;
		p = cpu_clk_en_out;
		while (k < 2) begin
			@(posedge clock_in);
			n++;
			if (cpu_clk_en_out && !p) begin
				k++;
				if (k == 1) n = 0;
			end
			p = cpu_clk_en_out;
		end
		chk(n, e);
		chk(clk_out_oe_out, 1'b1);
	endtask
	task automatic end_of_test;
		if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock_in);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		rd(8'h29, 8'h01);
		rd(8'h29, 8'h00);
		rd(8'h55, 8'h00);
		wr(8'h29, 8'hfe);
		rd(8'h29, 8'h0e);
		@(posedge clock_in iff rtc_irq_out === 1'b1);
		c0 = cyc;
		rd(8'h29, 8'h0f);
		wait (rtc_irq_out === 1'b0);
		@(posedge clock_in iff rtc_irq_out === 1'b1);
		chk(cyc - c0, 250);
		rd(8'h30, 8'h03);
		wr(8'h31, 8'h02);
		@(posedge clock_in);
		#1 chk(irq_out, 1'b1);
		wr(8'h30, 8'h03);
		repeat (2) @(posedge clock_in);
		#1 chk(irq_out, 1'b0);
		@(posedge clock_in);
		cpu_irq_mask_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		#1 chk(rtc_irq_out, 1'b0);
		@(posedge clock_in);
		cpu_irq_mask_in <= 1'b0;
		wait_mode_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		#1 chk(rtc_irq_out, 1'b1);
		chk(wake_out, 1'b1);
		@(posedge clock_in);
		wait_mode_in <= 1'b0;
		clk_en_in <= 1'b0;
		@(posedge clock_in);
		#1 c0 = can_clk_out;
		repeat (3) @(posedge clock_in);
		#1 chk(can_clk_out, c0);
		@(posedge clock_in);
		clk_en_in <= 1'b1;
		per(8'h20, 2);
		per(8'h21, 4);
		per(8'h25, 8);
		per(8'h23, 16);
		per(8'h27, 32);
		rd(8'h29, 8'h0f);
		pls(1'b1);
		chk(timed_halt_out, 1'b1);
		rd(8'h29, 8'h00);
		@(posedge clock_in iff timed_halt_out === 1'b0);
		wr(8'h29, 8'h00);
		pls(1'b1);
		chk(full_halt_out, 1'b1);
		repeat (300) @(posedge clock_in);
		chk(full_halt_out, 1'b1);
		pls(1'b0);
		chk(full_halt_out, 1'b0);
		@(posedge clock_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		rd(8'h29, 8'h01);
		repeat (25) @(posedge clock_in);
		rd(8'h30, 8'h01);
		end_of_test;
	end
endmodule // tb_mcr_clock_ctrl
